// >>> aac_cfg.sv
// aac_cfg: aperture size, aperture base, translation table base and the two arbiter time slices.
// assumes an APB master on the same clock, and agents whose requests are synchronous to clk.
//
// How it works
// - aperture size select resets to zero, meaning the 64 MB aperture
// - size bit clear: aperture base bit 25 reads zero and ignores writes
// - size bit set: aperture base bit 25 is a normal read/write bit
// - size bit at position 3: 0 means 64 MB, 1 means 32 MB
// - table base keeps bits 28:12 only, so it is 4 KB aligned
// - translation uses the table base to form the entry fetch address
// - a new table base is used by the next fetch, no quiescing needed
// - when the owner's multi-transaction slice expires the other agent gets the bus
// - multi-transaction slice of zero disables the slice mechanism
// - multi-transaction count in bits 7:3, value read as a clock count
// - low-priority slice guarantees minimum tenure for low-priority transfers
// - low-priority slice spans the whole transfer state, over several transactions
// - after low-priority expiry yield only if another request is pending
// - high-priority requests never wait for the low-priority slice
// - low-priority slice of zero disables the minimum tenure
// - low-priority count in bits 7:3, value read as a clock count
`timescale 1ns/10ps
`default_nettype none
module aac_cfg (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // apb slave
  input  wire aac_pkg::aac_apb_req_s  apb_req,
  output var  aac_pkg::aac_apb_rsp_s  apb_rsp,
  // multi-transaction arbiter
  input  wire aac_pkg::aac_arb_req_s  arb_req,
  output logic                        agp_grant,
  output logic                        host_grant,
  // low-priority tenure
  input  wire aac_pkg::aac_lp_req_s   lp_req,
  output logic                        lp_yield,
  // translation entry fetch
  input  wire logic                   xlat_valid,
  input  wire logic [31:0]            xlat_addr,
  output logic                        entry_valid,
  output var  aac_pkg::aac_xlat_rsp_s xlat_rsp,
  // configuration view
  output logic                        aperture_32mb
);
  import aac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]  aperture_size_select;
  logic [31:0] aperture_base;
  logic [31:0] translation_table_base;
  logic [7:0]  multi_transaction_slice;
  logic [7:0]  low_priority_slice;
  logic        size_bit;
  logic [31:0] base_mask;

  // bus decode
  logic [ADDR_W-1:0] a_size;
  logic [ADDR_W-1:0] a_base;
  logic [ADDR_W-1:0] a_table;
  logic [ADDR_W-1:0] a_mts;
  logic [ADDR_W-1:0] a_lps;
  logic              setup_phase;
  logic              wr_take;
  logic              sel_size;
  logic              sel_base;
  logic              sel_table;
  logic              sel_mts;
  logic              sel_lps;
  logic              sel_any;
  logic [31:0]       next_prdata;
  logic [31:0]       lane_mask;

  assign a_size  = ADDR_W'({IDX_APERTURE_SIZE_SELECT, 2'b00});
  assign a_base  = ADDR_W'({IDX_APERTURE_BASE, 2'b00});
  assign a_table = ADDR_W'({IDX_TRANSLATION_TABLE_BASE, 2'b00});
  assign a_mts   = ADDR_W'({IDX_MULTI_TRANSACTION_SLICE, 2'b00});
  assign a_lps   = ADDR_W'({IDX_LOW_PRIORITY_SLICE, 2'b00});

  // no wait state: read data is captured in setup so prdata comes from a flop
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign wr_take     = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;

  // address decoding
  always_comb begin
    sel_size  = 1'b0;
    sel_base  = 1'b0;
    sel_table = 1'b0;
    sel_mts   = 1'b0;
    sel_lps   = 1'b0;
    if (apb_req.paddr == a_size) begin
      sel_size = 1'b1;
    end else if (apb_req.paddr == a_base) begin
      sel_base = 1'b1;
    end else if (apb_req.paddr == a_table) begin
      sel_table = 1'b1;
    end else if (apb_req.paddr == a_mts) begin
      sel_mts = 1'b1;
    end else if (apb_req.paddr == a_lps) begin
      sel_lps = 1'b1;
    end
  end
  assign sel_any = sel_size | sel_base | sel_table | sel_mts | sel_lps;

  // byte enables widened to a bit mask
  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{apb_req.pstrb[gi]}};
    end
  endgenerate

  // read mux; reserved bits are never stored so they read zero
  always_comb begin
    next_prdata = 32'h00000000;
    if (sel_size) begin
      next_prdata = {24'h000000, aperture_size_select};
    end else if (sel_base) begin
      next_prdata = aperture_base & base_mask; // bit 25 reads zero even in the cycle it is cleared
    end else if (sel_table) begin
      next_prdata = translation_table_base;
    end else if (sel_mts) begin
      next_prdata = {24'h000000, multi_transaction_slice};
    end else if (sel_lps) begin
      next_prdata = {24'h000000, low_priority_slice};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: pready high in the access cycle that follows setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      apb_rsp.pready <= 1'b0;
    end else begin
      apb_rsp.pready <= setup_phase;
    end
  end

  // read data and error captured in setup; unmapped addresses answer pslverr
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      apb_rsp.prdata  <= 32'h00000000;
      apb_rsp.pslverr <= 1'b0;
    end else if (setup_phase) begin
      apb_rsp.prdata  <= apb_req.pwrite ? 32'h00000000 : next_prdata;
      apb_rsp.pslverr <= ~sel_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aperture size select: only the size bit is stored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aperture_size_select <= RST_APERTURE_SIZE_SELECT;
    end else if (wr_take && sel_size && apb_req.pstrb[0]) begin
      aperture_size_select <= apb_req.pwdata[7:0] & (8'h01 << SIZE_BIT_POS);
    end
  end

  // size bit decode: 0 is 64 MB, 1 is 32 MB
  assign size_bit = aperture_size_select[SIZE_BIT_POS];

  // aperture base: bits 31:26 always writable, bit 25 gated by the size bit
  always_comb begin
    base_mask = 32'h00000000;
    base_mask[31:BASE_FIELD_LO] = '1;
    base_mask[BASE_GATED_BIT]   = size_bit;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aperture_base <= RST_APERTURE_BASE;
    end else if (wr_take && sel_base) begin
      aperture_base <= ((apb_req.pwdata & lane_mask) | (aperture_base & ~lane_mask)) & base_mask;
    end else if (!size_bit) begin
      aperture_base[BASE_GATED_BIT] <= 1'b0; // clearing the size bit drops bit 25 too
    end
  end

  // translation table base: only bits 28:12 are kept, 4 KB alignment by construction
  logic [31:0] table_mask;
  always_comb begin
    table_mask = 32'h00000000;
    table_mask[TABLE_FIELD_HI:TABLE_FIELD_LO] = '1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      translation_table_base <= RST_TRANSLATION_TABLE_BASE;
    end else if (wr_take && sel_table) begin
      translation_table_base <= ((apb_req.pwdata & lane_mask) | (translation_table_base & ~lane_mask))
                                & table_mask;
    end
  end

  // slice registers keep bits 7:3, low three bits are reserved
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      multi_transaction_slice <= RST_MULTI_TRANSACTION_SLICE;
    end else if (wr_take && sel_mts && apb_req.pstrb[0]) begin
      multi_transaction_slice <= apb_req.pwdata[7:0] & SLICE_FIELD_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_priority_slice <= RST_LOW_PRIORITY_SLICE;
    end else if (wr_take && sel_lps && apb_req.pstrb[0]) begin
      low_priority_slice <= apb_req.pwdata[7:0] & SLICE_FIELD_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aperture_32mb <= 1'b0;
    end else begin
      aperture_32mb <= size_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multi-transaction arbiter between the agp master and the host bridge
  aac_owner_e owner;
  aac_owner_e next_owner;
  logic [7:0] mt_count;
  logic       mt_enabled;
  logic       mt_expired;
  logic       own_req;
  logic       other_req;

  assign mt_enabled = (multi_transaction_slice != 8'h00);
  // register value is the clock count, step of eight comes from the masked field
  assign mt_expired = mt_enabled && (mt_count >= multi_transaction_slice - 8'h01);

  always_comb begin
    own_req   = 1'b0;
    other_req = 1'b0;
    case (owner)
      AAC_OWN_AGP: begin
        own_req   = arb_req.agp_req;
        other_req = arb_req.host_req;
      end
      AAC_OWN_HOST: begin
        own_req   = arb_req.host_req;
        other_req = arb_req.agp_req;
      end
      default: begin
        own_req   = 1'b0;
        other_req = 1'b0;
      end
    endcase
  end

  // owner switches on slice expiry, or when the owner lets go
  always_comb begin
    next_owner = owner;
    case (owner)
      AAC_OWN_IDLE: begin
        if (arb_req.agp_req) begin
          next_owner = AAC_OWN_AGP;
        end else if (arb_req.host_req) begin
          next_owner = AAC_OWN_HOST;
        end
      end
      AAC_OWN_AGP: begin
        if ((mt_expired || !own_req) && other_req) begin
          next_owner = AAC_OWN_HOST;
        end else if (!own_req) begin
          next_owner = AAC_OWN_IDLE;
        end
      end
      AAC_OWN_HOST: begin
        if ((mt_expired || !own_req) && other_req) begin
          next_owner = AAC_OWN_AGP;
        end else if (!own_req) begin
          next_owner = AAC_OWN_IDLE;
        end
      end
      default: begin
        next_owner = AAC_OWN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      owner <= AAC_OWN_IDLE;
    end else begin
      owner <= next_owner;
    end
  end

  // slice counter restarts on every change of owner; saturates so a lone owner keeps the bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mt_count <= 8'h00;
    end else if (next_owner != owner || owner == AAC_OWN_IDLE) begin
      mt_count <= 8'h00;
    end else if (mt_enabled && !mt_expired) begin
      mt_count <= mt_count + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      agp_grant  <= 1'b0;
      host_grant <= 1'b0;
    end else begin
      agp_grant  <= (next_owner == AAC_OWN_AGP);
      host_grant <= (next_owner == AAC_OWN_HOST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-priority minimum tenure
  logic [7:0] lp_count;
  logic       lp_enabled;
  logic       lp_expired;
  logic       next_lp_yield;

  assign lp_enabled = (low_priority_slice != 8'h00);
  assign lp_expired = !lp_enabled || (lp_count >= low_priority_slice);

  // count runs over the whole transfer state, not per transaction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lp_count <= 8'h00;
    end else if (!lp_req.lp_active) begin
      lp_count <= 8'h00;
    end else if (lp_enabled && !lp_expired) begin
      lp_count <= lp_count + 8'h01;
    end
  end

  // high priority cuts in at once; others wait for expiry and only if pending
  always_comb begin
    next_lp_yield = 1'b0;
    if (lp_req.hp_req) begin
      next_lp_yield = 1'b1;
    end else if (lp_req.lp_active && lp_expired && lp_req.other_pending) begin
      next_lp_yield = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lp_yield <= 1'b0;
    end else begin
      lp_yield <= next_lp_yield;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // translation entry address: one 4-byte entry per 4 KB aperture page
  logic [13:0] page_idx;
  logic        next_hit;

  // in the 32 MB case the top page bit belongs to the base compare
  always_comb begin
    page_idx = xlat_addr[BASE_GATED_BIT:PAGE_SHIFT];
    if (size_bit) begin
      page_idx[13] = 1'b0;
    end
  end
  assign next_hit = ((xlat_addr ^ aperture_base) & base_mask) == 32'h00000000;

  // the table base is read live, so a rewrite steers the very next fetch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      entry_valid         <= 1'b0;
      xlat_rsp.hit        <= 1'b0;
      xlat_rsp.entry_addr <= 32'h00000000;
    end else begin
      entry_valid <= xlat_valid;
      if (xlat_valid) begin
        xlat_rsp.hit        <= next_hit;
        xlat_rsp.entry_addr <= translation_table_base + {16'h0000, page_idx, 2'b00};
      end
    end
  end

endmodule // aac_cfg
`default_nettype wire

// >>> aac_pkg.sv
// aac_pkg: constants, states and carrier structs for the aperture and arbiter configuration block.
// assumes one 100 MHz clock domain and an APB register bus with 32-bit data.
`default_nettype none
package aac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices as printed, byte address is four times the index
  localparam logic [7:0]  IDX_APERTURE_SIZE_SELECT   = 8'hB4;
  localparam logic [7:0]  IDX_TRANSLATION_TABLE_BASE = 8'hB8;
  localparam logic [7:0]  IDX_MULTI_TRANSACTION_SLICE = 8'hBC;
  localparam logic [7:0]  IDX_LOW_PRIORITY_SLICE     = 8'hBD;
  localparam logic [7:0]  IDX_APERTURE_BASE          = 8'h10;
  localparam int          ADDR_W                     = 12;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and masks
  localparam int          SIZE_BIT_POS     = 3;
  localparam int          BASE_GATED_BIT   = 25;
  localparam int          BASE_FIELD_LO    = 26;
  localparam int          TABLE_FIELD_HI   = 28;
  localparam int          TABLE_FIELD_LO   = 12;
  localparam int          PAGE_SHIFT       = 12;
  localparam logic [7:0]  SLICE_FIELD_MASK = 8'hF8;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0]  RST_APERTURE_SIZE_SELECT    = 8'h00;
  localparam logic [31:0] RST_TRANSLATION_TABLE_BASE  = 32'h00000000;
  localparam logic [7:0]  RST_MULTI_TRANSACTION_SLICE = 8'h00;
  localparam logic [7:0]  RST_LOW_PRIORITY_SLICE      = 8'h00;
  localparam logic [31:0] RST_APERTURE_BASE           = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // multi-transaction arbiter owner states, gray along idle-agp-host
  typedef enum logic [1:0] {
    AAC_OWN_IDLE = 2'b00,
    AAC_OWN_AGP  = 2'b01,
    AAC_OWN_HOST = 2'b11
  } aac_owner_e;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } aac_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aac_apb_rsp_s;

  typedef struct packed {
    logic agp_req;
    logic host_req;
  } aac_arb_req_s;

  typedef struct packed {
    logic lp_active;
    logic other_pending;
    logic hp_req;
  } aac_lp_req_s;

  typedef struct packed {
    logic        hit;
    logic [31:0] entry_addr;
  } aac_xlat_rsp_s;

endpackage : aac_pkg
`default_nettype wire

// >>> aac_cfg_asserts.sv
// aac_cfg_asserts: port-level checks on the aperture and arbiter configuration block.
// assumes it is bound to aac_cfg and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module aac_cfg_asserts (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   sys_rst,
  // apb
  input wire aac_pkg::aac_apb_req_s  apb_req,
  input wire aac_pkg::aac_apb_rsp_s  apb_rsp,
  // arbiter and tenure
  input wire aac_pkg::aac_arb_req_s  arb_req,
  input wire logic                   agp_grant,
  input wire logic                   host_grant,
  input wire aac_pkg::aac_lp_req_s   lp_req,
  input wire logic                   lp_yield,
  // translation and size
  input wire logic                   xlat_valid,
  input wire logic [31:0]            xlat_addr,
  input wire logic                   entry_valid,
  input wire aac_pkg::aac_xlat_rsp_s xlat_rsp,
  input wire logic                   aperture_32mb
);
  import aac_pkg::*;
  logic        acc;
  logic        rdx;
  logic [31:0] rdat;
  logic [11:0] a;
  // completed access; read data only means something on reads
  assign acc  = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign rdx  = acc && !apb_req.pwrite;
  assign rdat = apb_rsp.prdata;
  assign a    = apb_req.paddr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  AST_SIZE_RESET: assert property ($past(sys_rst) |-> !aperture_32mb)
    else $error("size bit set right after reset");
  AST_BASE25_LOW: assert property (rdx && a == 12'h040 && !aperture_32mb |-> !rdat[25])
    else $error("base bit 25 read high in 64 MB mode");
  AST_SIZE_WRITE: assert property (acc && apb_req.pwrite && a == 12'h2D0 && apb_req.pstrb[0]
    |-> ##2 aperture_32mb == $past(apb_req.pwdata[3], 2))
    else $error("size view does not follow written bit 3");
  AST_TABLE_RSV: assert property (rdx && a == 12'h2E0 |-> rdat[31:29] == 3'h0 && rdat[11:0] == 12'h000)
    else $error("table base reserved bits read nonzero");
  AST_ENTRY_PULSE: assert property (entry_valid == $past(xlat_valid))
    else $error("entry valid not one cycle after request");
  AST_GRANT_ONEHOT: assert property (!(agp_grant && host_grant))
    else $error("both agents granted");
  AST_MT_RSV: assert property (rdx && a == 12'h2F0 |-> rdat[31:8] == 24'h000000 && rdat[2:0] == 3'h0)
    else $error("multi-transaction slice reserved bits nonzero");
  AST_LP_RSV: assert property (rdx && a == 12'h2F4 |-> rdat[31:8] == 24'h000000 && rdat[2:0] == 3'h0)
    else $error("low-priority slice reserved bits nonzero");
  AST_HP_YIELD: assert property (lp_req.hp_req |=> lp_yield)
    else $error("high-priority request did not get the bus");
  AST_NO_PEND: assert property (!lp_req.hp_req && !lp_req.other_pending |=> !lp_yield)
    else $error("yield with nobody waiting");
  AST_SIZE_RSV: assert property (rdx && a == 12'h2D0 |-> rdat[31:4] == 28'h0000000 && rdat[2:0] == 3'h0)
    else $error("size register reserved bits nonzero");
endmodule // aac_cfg_asserts
bind aac_cfg aac_cfg_asserts aac_cfg_asserts_i (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .arb_req(arb_req), .agp_grant(agp_grant), .host_grant(host_grant), .lp_req(lp_req),
  .lp_yield(lp_yield), .xlat_valid(xlat_valid), .xlat_addr(xlat_addr), .entry_valid(entry_valid),
  .xlat_rsp(xlat_rsp), .aperture_32mb(aperture_32mb));
`default_nettype wire

// >>> aac_agents.sv
// aac_agents: the graphics master and host bridge as seen by the arbiter.
// assumes the bench says when each agent wants the bus.
`timescale 1ns/10ps
`default_nettype none
module aac_agents (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // bench controls
  input  wire logic                  want_agp,
  input  wire logic                  want_host,
  // requests to the arbiter
  output var  aac_pkg::aac_arb_req_s arb_req
);
  import aac_pkg::*;
  // requests come from flops, as real masters launch them off the edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arb_req <= '0;
    end else begin
      arb_req.agp_req  <= want_agp;
      arb_req.host_req <= want_host;
    end
  end
endmodule // aac_agents
`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for aac_cfg over apb, arbiter, tenure and translation ports.
// assumes aac_cfg_asserts is bound in and aac_agents makes the bus requests.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import aac_pkg::*;
  logic          clk, sys_rst, agp_grant, host_grant, lp_yield, xlat_valid, entry_valid, aperture_32mb;
  logic          want_agp, want_host, err;
  aac_apb_req_s  apb_req;
  aac_apb_rsp_s  apb_rsp;
  aac_arb_req_s  arb_req;
  aac_lp_req_s   lp_req;
  aac_xlat_rsp_s xlat_rsp;
  logic [31:0]   xlat_addr, rd;
  int            errors, n_checks, cyc, n;

  aac_cfg aac_cfg_i (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .arb_req(arb_req),
    .agp_grant(agp_grant), .host_grant(host_grant), .lp_req(lp_req), .lp_yield(lp_yield), .xlat_valid(xlat_valid),
    .xlat_addr(xlat_addr), .entry_valid(entry_valid), .xlat_rsp(xlat_rsp), .aperture_32mb(aperture_32mb));
  aac_agents aac_agents_i (.clk(clk), .sys_rst(sys_rst), .want_agp(want_agp), .want_host(want_host),
    .arb_req(arb_req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; waits for pready, so slow answers are fine
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(w, e, rd);
  endtask
  task automatic xl(input logic [31:0] a, input logic [31:0] e, input logic h);
    @(posedge clk);
    xlat_valid <= 1'b1;
    xlat_addr  <= a;
    @(posedge clk);
    xlat_valid <= 1'b0;
    @(posedge clk);
    chk("entry_valid", 32'h00000001, {31'h0, entry_valid});
    chk("entry_addr", e, xlat_rsp.entry_addr);
    chk("hit", {31'h0, h}, {31'h0, xlat_rsp.hit});
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rdc("size rst", 12'h2D0, 32'h00000000);
    rdc("table rst", 12'h2E0, 32'h00000000);
    rdc("mt rst", 12'h2F0, 32'h00000000);
    rdc("lp rst", 12'h2F4, 32'h00000000);
    apb(1'b1, 12'h2D0, 32'hFFFFFFFF);
    rdc("size", 12'h2D0, 32'h00000008);
    chk("size view", 32'h00000001, {31'h0, aperture_32mb});
    apb(1'b1, 12'h2F0, 32'hFFFFFFFF);
    rdc("mt", 12'h2F0, 32'h000000F8);
    apb(1'b1, 12'h2F4, 32'hFFFFFFFF);
    rdc("lp", 12'h2F4, 32'h000000F8);
    apb(1'b1, 12'h2E0, 32'hFFFFFFFF);
    rdc("table", 12'h2E0, 32'h1FFFF000);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    chk("unmapped err", 32'h00000001, {31'h0, err});
    $display("test regs done");
  endtask
  task automatic t_base();
    apb(1'b1, 12'h040, 32'hFE000000);
    rdc("base 32mb", 12'h040, 32'hFE000000);
    apb(1'b1, 12'h2D0, 32'h00000000);
    rdc("base cleared", 12'h040, 32'hFC000000);
    apb(1'b1, 12'h040, 32'hFFFFFFFF);
    rdc("base 64mb", 12'h040, 32'hFC000000);
    $display("test base done");
  endtask
  task automatic t_xlat();
    apb(1'b1, 12'h2E0, 32'h12345FFF);
    xl(32'hFC005000, 32'h12345014, 1'b1);
    apb(1'b1, 12'h2E0, 32'h00002000);
    xl(32'hFC005000, 32'h00002014, 1'b1);
    xl(32'h00005000, 32'h00002014, 1'b0);
    $display("test xlat done");
  endtask
  task automatic t_mt();
    apb(1'b1, 12'h2F0, 32'h00000008);
    want_agp  <= 1'b1;
    want_host <= 1'b1;
    do @(posedge clk); while (agp_grant !== 1'b1);
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (host_grant !== 1'b1);
    chk("agp slice", 32'd8, n);
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (agp_grant !== 1'b1);
    chk("host slice", 32'd8, n);
    apb(1'b1, 12'h2F0, 32'h00000000);
    repeat (10) @(posedge clk);
    err = agp_grant;
    n = 0;
    repeat (40) begin @(posedge clk); if (agp_grant !== err) n = n + 1; end
    chk("no slice switch", 32'd0, n);
    want_agp  <= 1'b0;
    want_host <= 1'b0;
    repeat (4) @(posedge clk);
    chk("grants idle", 32'd0, {30'h0, agp_grant, host_grant});
    $display("test mt done");
  endtask
  // lp_req bits are lp_active, other_pending, hp_req
  task automatic t_lp();
    apb(1'b1, 12'h2F4, 32'h00000010);
    lp_req <= 3'h6;
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (lp_yield !== 1'b1);
    chk("lp tenure 16", 32'd1, {31'h0, n >= 16 && n <= 18});
    lp_req <= 3'h4;
    // the yield launched at the edge that saw the pending request still stands one cycle
    @(posedge clk);
    n = 0;
    repeat (30) begin @(posedge clk); if (lp_yield !== 1'b0) n = n + 1; end
    chk("lp no pending", 32'd0, n);
    lp_req <= 3'h0;
    @(posedge clk);
    lp_req <= 3'h5;
    repeat (2) @(posedge clk);
    chk("hp yield", 32'd1, {31'h0, lp_yield});
    // drop everything so the next yield can only come from the disabled slice
    lp_req <= 3'h0;
    apb(1'b1, 12'h2F4, 32'h00000000);
    lp_req <= 3'h6;
    repeat (2) @(posedge clk);
    chk("lp off yield", 32'd1, {31'h0, lp_yield});
    lp_req <= 3'h0;
    $display("test lp done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst    = 1'b1;
    apb_req    = '0;
    lp_req     = '0;
    xlat_valid = 1'b0;
    xlat_addr  = '0;
    want_agp   = 1'b0;
    want_host  = 1'b0;
    errors     = 0;
    n_checks   = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_base();
    t_xlat();
    t_mt();
    t_lp();
    finish_test();
  end
endmodule // tb
`default_nettype wire
